// [hw/baseline_store.sv]
// Three-entry memory of 10-bit baselines; read data registered.
// Assumes the filter writes one entry at a time.
`timescale 1ns/1ps
module baseline_store
    import touch_sense_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_idx,
    input  wire logic [9:0] wr_data,
    input  wire logic [1:0] rd_idx,
    output logic      [9:0] rd_data
);
    logic [9:0] mem [num_electrodes];

    // ==============================
    // Storage, one entry per electrode
    genvar g;
    generate
        for (g = 0; g < num_electrodes; g++)
        begin : g_ent
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    mem[g] <= 10'h000;
                else if (wr_en && wr_idx == 2'(g))
                    mem[g] <= wr_data;
            end
        end
    endgenerate

    // Registered read
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_data <= 10'h000;
        else
            rd_data <= (rd_idx < 2'(num_electrodes)) ? mem[rd_idx] : 10'h000;
    end
endmodule : baseline_store

// [hw/touch_sense_measure_irq.sv]
// Measurement sequencer, configuration registers and latching interrupt.
// Assumes a decoded single-cycle register port; touch status from detector.
//
// Contract
// - baseline byte is upper eight of ten bits
// - baselines at 0x1A, 0x1B, 0x1C
// - interrupt on any touch status change; changes are masked while the over-current flag is set
// - host read releases pending interrupt
// - active-low open-drain latching interrupt pin
// - ground, charge for time, then sample
// - other electrodes held grounded meanwhile
// - discharge with same current and time
// - averaging depth from bits 7:6
// - charge current bits 5:0, zero disables
// - front-end configuration at 0x41
// - charge time 500 ns to 32 us
// - status at 0x00, over-current write-one clear
// - interrupt only with one or two electrodes
`timescale 1ns/1ps
module touch_sense_measure_irq
    import touch_sense_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire touch_sense_pkg::reg_req_t req,
    output logic          [7:0] rdata,
    input  wire logic     [3:0] electrode_enable_field,
    input  wire logic     [2:0] touch_in,
    input  wire logic           over_current_event,
    input  wire logic           baseline_wr,
    input  wire logic     [1:0] baseline_idx,
    input  wire logic     [9:0] baseline_value,
    input  wire logic           start,
    output touch_sense_pkg::front_end_ctl_t fe_ctl,
    output logic          [1:0] meas_electrode,
    output logic          [5:0] first_stage_sample_count,
    output logic                irq_n_out,
    output logic                irq_n_oe
);
    import touch_sense_pkg::*;

    logic [7:0]  front_end_config;
    logic [7:0]  filter_cfg;
    logic [2:0]  touch_status;
    logic        over_current_flag;
    logic        irq_pending;
    meas_state_t state;
    logic [15:0] timer;
    logic [15:0] charge_cycles;
    logic [1:0]  active;
    logic [9:0]  base_rd;
    logic [1:0]  base_idx;
    logic        rd_base_d;
    logic        status_changed;
    logic        irq_allowed;

    // ==============================
    // Register writes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            front_end_config <= front_end_reset;
            filter_cfg       <= filter_cfg_reset;
        end
        else if (req.wr && req.addr == addr_front_end)
            front_end_config <= req.wdata;
        else if (req.wr && req.addr == addr_filter_cfg)
            filter_cfg <= req.wdata;
    end

    // Over-current flag, event beats write-one clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            over_current_flag <= 1'b0;
        else if (over_current_event)
            over_current_flag <= 1'b1;
        else if (req.wr && req.addr == addr_touch_status && req.wdata[over_current_bit])
            over_current_flag <= 1'b0;
    end

    // Touch status capture; flag clears status
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            touch_status <= 3'h0;
        else if (over_current_flag)
            touch_status <= 3'h0;
        else
            touch_status <= touch_in;
    end

    // ==============================
    // Interrupt latch
    assign status_changed = !over_current_flag && (touch_in != touch_status);
    assign irq_allowed = (electrode_enable_field != enable_stop) &&
                         (electrode_enable_field <= enable_two);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_pending <= 1'b0;
        else if (status_changed)
            irq_pending <= 1'b1;
        else if (req.rd)
            irq_pending <= 1'b0;
    end

    // Open-drain pin: enable low pulls the line low
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= 1'b1;
        end
        else
        begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= !(irq_allowed && (irq_pending || status_changed));
        end
    end

    // ==============================
    // Read path
    assign base_idx = 2'(req.addr - addr_baseline0);

    baseline_store u_base (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (baseline_wr),
        .wr_idx  (baseline_idx),
        .wr_data (baseline_value),
        .rd_idx  (base_idx),
        .rd_data (base_rd)
    );

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_base_d <= 1'b0;
        else
            rd_base_d <= req.rd && (req.addr >= addr_baseline0) &&
                         (req.addr <= addr_baseline2);
    end

    // Read data mux, baselines arrive one cycle after the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= zero_byte;
        else if (rd_base_d)
            rdata <= base_rd[9:2];
        else if (req.rd)
        begin
            unique case (req.addr)
                addr_touch_status: rdata <= {over_current_flag, 4'h0, touch_status};
                addr_front_end:    rdata <= front_end_config;
                addr_filter_cfg:   rdata <= filter_cfg;
                default:           rdata <= zero_byte;
            endcase
        end
    end

    // ==============================
    // Averaging depth decode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            first_stage_sample_count <= depth_code0_samples;
        else
        begin
            unique case (front_end_config[sample_count_hi:sample_count_lo])
                2'd0: first_stage_sample_count <= depth_code0_samples;
                2'd1: first_stage_sample_count <= depth_code1_samples;
                2'd2: first_stage_sample_count <= depth_code2_samples;
                2'd3: first_stage_sample_count <= depth_code3_samples;
            endcase
        end
    end

    // Charge time: code n gives 500 ns times 2^(n-1); code 0 treated as 1
    assign charge_cycles = (filter_cfg[charge_time_hi:charge_time_lo] == 3'd0) ?
        16'(charge_min_cycles) :
        16'(charge_min_cycles) << (filter_cfg[charge_time_hi:charge_time_lo] - 3'd1);

    // ==============================
    // Measurement sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state  <= st_idle;
            timer  <= 16'h0000;
            active <= 2'd0;
        end
        else
        begin
            unique case (state)
                st_idle:
                    if (start && !over_current_flag &&
                        front_end_config[charge_current_hi:charge_current_lo] != charge_off)
                    begin
                        state <= st_ground;
                        timer <= 16'(ground_cycles);
                    end
                st_ground:
                    if (timer == 16'h0001)
                    begin
                        state <= st_charge;
                        timer <= charge_cycles;
                    end
                    else
                        timer <= timer - 16'h0001;
                st_charge:
                    if (timer == 16'h0001)
                        state <= st_sample;
                    else
                        timer <= timer - 16'h0001;
                st_sample:
                begin
                    state <= st_discharge;
                    timer <= charge_cycles;
                end
                st_discharge:
                    if (timer == 16'h0001)
                    begin
                        state  <= st_idle;
                        active <= (active == 2'(num_electrodes - 1) ||
                                   (irq_allowed && active == 2'(electrode_enable_field) - 2'd1))
                                  ? 2'd0 : active + 2'd1;
                    end
                    else
                        timer <= timer - 16'h0001;
                default:
                    state <= st_idle;
            endcase
        end
    end

    // Front-end drive, one-hot on the active electrode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fe_ctl         <= '{ground: 3'h7, charge: 3'h0, discharge: 3'h0,
                                current: 6'h00, sample: 1'b0};
            meas_electrode <= 2'd0;
        end
        else
        begin
            meas_electrode    <= active;
            fe_ctl.current    <= front_end_config[charge_current_hi:charge_current_lo];
            fe_ctl.sample     <= (state == st_sample);
            fe_ctl.charge     <= (state == st_charge) ? (3'h1 << active) : 3'h0;
            fe_ctl.discharge  <= (state == st_discharge) ? (3'h1 << active) : 3'h0;
            fe_ctl.ground     <= (state == st_charge || state == st_sample ||
                                  state == st_discharge) ? ~(3'h1 << active) : 3'h7;
        end
    end
endmodule : touch_sense_measure_irq

// [hw/touch_sense_pkg.sv]
// Constants and carrier types for the touch sense measurement block.
// Assumes a 200 MHz core clock and a register port decoded upstream.
package touch_sense_pkg;
    // ==============================
    // Register map
    localparam logic [7:0] addr_touch_status = 8'h00;
    localparam logic [7:0] addr_baseline0    = 8'h1A;
    localparam logic [7:0] addr_baseline1    = 8'h1B;
    localparam logic [7:0] addr_baseline2    = 8'h1C;
    localparam logic [7:0] addr_front_end    = 8'h41;
    localparam logic [7:0] addr_filter_cfg   = 8'h43;
    localparam logic [7:0] front_end_reset   = 8'h00;
    localparam logic [7:0] filter_cfg_reset  = 8'h20;
    localparam logic [3:0] enable_reset      = 4'h0;
    // ==============================
    // Field positions
    localparam int sample_count_hi = 7;
    localparam int sample_count_lo = 6;
    localparam int charge_current_hi = 5;
    localparam int charge_current_lo = 0;
    localparam int charge_time_hi = 7;
    localparam int charge_time_lo = 5;
    localparam int over_current_bit = 7;
    // Averaging depth per code
    localparam logic [5:0] depth_code0_samples = 6'h06;
    localparam logic [5:0] depth_code1_samples = 6'h0A;
    localparam logic [5:0] depth_code2_samples = 6'h12;
    localparam logic [5:0] depth_code3_samples = 6'h22;
    localparam int num_electrodes = 3;
    localparam logic [5:0] charge_off = 6'h00;
    localparam logic [3:0] enable_two = 4'h2;
    localparam logic [3:0] enable_stop = 4'h0;
    // ==============================
    // Timing
    localparam int clk_mhz = 200;
    localparam int charge_time_min_ns = 500;
    localparam int charge_min_cycles = (charge_time_min_ns * clk_mhz + 999) / 1000;
    localparam int ground_cycles = 1;
    localparam logic [7:0] zero_byte = 8'h00;
    // ==============================
    // Types
    typedef enum logic [2:0] {
        st_idle      = 3'b000,
        st_ground    = 3'b001,
        st_charge    = 3'b011,
        st_sample    = 3'b010,
        st_discharge = 3'b110
    } meas_state_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [2:0] ground;
        logic [2:0] charge;
        logic [2:0] discharge;
        logic [5:0] current;
        logic       sample;
    } front_end_ctl_t;
endpackage : touch_sense_pkg

// [verif/irq_host_model.sv]
// Host side of the interrupt wire, with the board pull-up.
// Assumes the block drives low while its output enable is low.
`timescale 1ns/1ps
module irq_host_model
(
    input  wire logic irq_n_out,
    input  wire logic irq_n_oe,
    output logic      irq_line
);
    // Pull-up wins whenever the pin is released
    assign irq_line = irq_n_oe ? 1'b1 : irq_n_out;
endmodule : irq_host_model

// [verif/tb_top.sv]
// Self-checking bench for the measure and interrupt block.
// Assumes the host model resolves the interrupt wire.
`timescale 1ns/1ps
module tb_top;
    import touch_sense_pkg::*;
    logic           clk;
    logic           rstn;
    reg_req_t       req;
    logic     [7:0] rdata;
    logic     [3:0] electrode_enable_field;
    logic     [2:0] touch_in;
    logic           over_current_event;
    logic           baseline_wr;
    logic     [1:0] baseline_idx;
    logic     [9:0] baseline_value;
    logic           start;
    front_end_ctl_t fe_ctl;
    logic     [5:0] first_stage_sample_count;
    logic     [1:0] meas_electrode;
    logic           irq_n_out;
    logic           irq_n_oe;
    logic           irq_line;
    int             bad_count;
    int             n_checks;
    int             nc;
    int             nd;
    touch_sense_measure_irq i_dut (.clk, .rstn, .req, .rdata, .electrode_enable_field,
        .touch_in, .over_current_event, .baseline_wr, .baseline_idx, .baseline_value,
        .start, .fe_ctl, .meas_electrode, .first_stage_sample_count, .irq_n_out, .irq_n_oe);
    irq_host_model i_host (.irq_n_out, .irq_n_oe, .irq_line);
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // =====
    // Tasks
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{r, !r, a, d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask : acc
    task automatic wait_irq(input logic e);
        repeat (4) @(posedge clk);
        #1;
        check(irq_line, e);
    endtask : wait_irq
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // Watchdog
    initial
    begin
        #100000;
        bad_count++;
        finish_test();
    end
    // =====
    // Tests
    initial
    begin
        rstn = 1'b0;
        req = '0;
        electrode_enable_field = 4'h0;
        touch_in = 3'h0;
        over_current_event = 1'b0;
        baseline_wr = 1'b0;
        baseline_idx = 2'h0;
        baseline_value = 10'h000;
        start = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b1, 8'h43, 8'h00);
        check(rdata, 8'h20);
        acc(1'b1, 8'h50, 8'h00);
        check(rdata, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            baseline_wr <= 1'b1;
            baseline_idx <= i[1:0];
            baseline_value <= 10'h3FD - 10'(i * 255);
            @(posedge clk);
            baseline_wr <= 1'b0;
            acc(1'b1, 8'h1A + 8'(i), 8'h00);
            // Baseline bytes pass the registered store, one edge later
            @(posedge clk);
            #1;
            check(rdata, 8'hFF - 8'(i * 64));
        end
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b0, 8'h41, {k[1:0], 6'h00});
            acc(1'b1, 8'h41, 8'h00);
            check(rdata, {k[1:0], 6'h00});
            check(first_stage_sample_count, (10'h004 << k) + 10'h002);
        end
        // Measurement: off with zero current, then one full cycle
        electrode_enable_field <= 4'h2;
        for (int m = 0; m < 2; m++)
        begin
            acc(1'b0, 8'h41, 8'(m));
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            nc = 0;
            nd = 0;
            repeat (260)
            begin
                @(posedge clk);
                #1;
                nc += int'(fe_ctl.charge != 3'h0);
                nd += int'(fe_ctl.discharge != 3'h0);
            end
            check(10'(nc), 10'(m * 100));
            check(10'(nd), 10'(m * 100));
        end
        check(meas_electrode, 10'd1);
        // Second electrode with doubled charge time, then wrap at two
        acc(1'b0, 8'h43, 8'h40);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        nc = 0;
        repeat (460)
        begin
            @(posedge clk);
            #1;
            nc += int'(fe_ctl.charge == 3'h2);
        end
        check(10'(nc), 10'd200);
        check(meas_electrode, 10'd0);
        // Touch, release and a change during the releasing read
        @(posedge clk);
        touch_in <= 3'h1;
        wait_irq(1'b0);
        acc(1'b1, 8'h00, 8'h00);
        check(rdata, 8'h01);
        wait_irq(1'b1);
        @(posedge clk);
        touch_in <= 3'h0;
        wait_irq(1'b0);
        @(posedge clk);
        touch_in <= 3'h2;
        req <= '{1'b1, 1'b0, 8'h00, 8'h00};
        @(posedge clk);
        req <= '0;
        wait_irq(1'b0);
        @(posedge clk);
        over_current_event <= 1'b1;
        @(posedge clk);
        over_current_event <= 1'b0;
        acc(1'b1, 8'h00, 8'h00);
        check(rdata, 8'h80);
        acc(1'b0, 8'h00, 8'h80);
        acc(1'b1, 8'h00, 8'h00);
        check(rdata, 8'h02);
        wait_irq(1'b1);
        @(posedge clk);
        electrode_enable_field <= 4'h3;
        touch_in <= 3'h4;
        wait_irq(1'b1);
        finish_test();
    end
endmodule : tb_top

// [verif/touch_sense_properties.sv]
// Port assertions for the measure and interrupt block.
// Assumes it is bound onto touch_sense_measure_irq.
`timescale 1ns/1ps
module touch_sense_checker
    import touch_sense_pkg::*;
(
    input wire logic           clk,
    input wire logic           rstn,
    input wire reg_req_t       req,
    input wire logic     [7:0] rdata,
    input wire logic     [3:0] electrode_enable_field,
    input wire logic     [2:0] touch_in,
    input wire front_end_ctl_t fe_ctl,
    input wire logic     [5:0] first_stage_sample_count,
    input wire logic           irq_n_out,
    input wire logic           irq_n_oe
);
    // =====
    // Interrupt
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic en_ok;
    assign en_ok = electrode_enable_field inside {4'h1, 4'h2};
    AST_PIN_LOW: assert property (irq_n_out == 1'b0)
        else $error("interrupt drive level not low");
    AST_IRQ_GATE: assert property (!en_ok [*3] |-> irq_n_oe)
        else $error("interrupt pulled while pin serves an electrode");
    AST_IRQ_SET: assert property ($changed(touch_in) && en_ok |-> ##[1:3] !irq_n_oe)
        else $error("status change raised no interrupt");
    AST_IRQ_HOLD: assert property (!irq_n_oe && en_ok && !req.rd && !$past(req.rd)
        |=> !irq_n_oe)
        else $error("interrupt let go without a read");
    AST_IRQ_REL: assert property (req.rd && $stable(touch_in) ##1 $stable(touch_in) [*2]
        |-> irq_n_oe)
        else $error("read did not release interrupt");
    // =====
    // Registers and sequencer
    AST_UNMAPPED: assert property (req.rd && !(req.addr inside
        {8'h00, 8'h1A, 8'h1B, 8'h1C, 8'h41, 8'h43}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_DEPTH: assert property (req.wr && req.addr == 8'h41 |-> ##2
        first_stage_sample_count == (6'h04 << $past(req.wdata[7:6], 2)) + 6'h02)
        else $error("sample count does not follow field");
    AST_GROUNDED: assert property (|fe_ctl.charge |->
        $onehot(fe_ctl.charge) && (fe_ctl.ground | fe_ctl.charge) == 3'h7)
        else $error("idle electrode not grounded");
    AST_CURRENT: assert property (|fe_ctl.charge |-> fe_ctl.current != 6'h00)
        else $error("charging with current off");
    AST_DISCHARGE: assert property ($fell(|fe_ctl.charge) |->
        fe_ctl.sample ##1 fe_ctl.discharge == $past(fe_ctl.charge, 2))
        else $error("sample or discharge out of order");
endmodule : touch_sense_checker
bind touch_sense_measure_irq touch_sense_checker i_chk (.clk, .rstn, .req, .rdata,
    .electrode_enable_field, .touch_in, .fe_ctl, .first_stage_sample_count,
    .irq_n_out, .irq_n_oe);
